// ==== design/usbd_pkg.sv ====
package usbd_pkg;
    // string table geometry
    localparam int unsigned NUM_STRINGS = 5;
    localparam logic [7:0] STR_IDX_FIRST = 8'h01;
    localparam logic [7:0] STR_IDX_LAST = 8'h05;
    localparam logic [7:0] STR_TYPE = 8'h03;
    localparam int unsigned NVM_ADDR_W = 16;

    // bulk companion descriptor content
    localparam logic [7:0] COMP_LEN = 8'h06;
    localparam logic [7:0] COMP_TYPE = 8'h30;
    localparam logic [7:0] COMP_ATTR = 8'h00;
    localparam logic [15:0] COMP_BPI = 16'h0000;
    localparam logic [3:0] BURST_DEFAULT = 4'h3;
    localparam logic [7:0] COMP_IDX_LEN = 8'h00;
    localparam logic [7:0] COMP_IDX_TYPE = 8'h01;
    localparam logic [7:0] COMP_IDX_BURST = 8'h02;
    localparam logic [7:0] COMP_IDX_ATTR = 8'h03;
    localparam logic [7:0] COMP_IDX_BPI_LO = 8'h04;
    localparam logic [7:0] COMP_IDX_BPI_HI = 8'h05;

    typedef enum logic [1:0] {
        REQ_STRING,
        REQ_COMP_IN,
        REQ_COMP_OUT
    } usbd_req_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD,
        ST_CAP,
        ST_SEND
    } usbd_state_t;

    typedef struct packed {
        usbd_req_kind_t kind;
        logic [7:0] index;
        logic [15:0] langid;
        logic [15:0] max_len;
    } usbd_req_t;

    typedef struct packed {
        logic [7:0] len;
        logic [NVM_ADDR_W-1:0] offset;
    } usbd_str_entry_t;

    typedef struct packed {
        logic [3:0] bulk_in_burst_size;
        logic [3:0] bulk_out_burst_size;
    } usbd_cfg0_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } usbd_tx_t;
endpackage : usbd_pkg

// ==== design/usbd_desc_resp.sv ====
`timescale 1ns/1ps
`default_nettype none
module usbd_desc_resp import usbd_pkg::*; (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // descriptor request
    input wire logic req_valid_i,
    input wire usbd_req_t req_i,
    output logic req_ready_o,
    // configuration-set insertion point
    input wire logic superspeed_i,
    input wire logic ep_desc_end_i,
    input wire logic ep_is_in_i,
    // nonvolatile image
    input wire logic nvm_image_valid_i,
    input wire usbd_str_entry_t str_table_i [NUM_STRINGS],
    output logic nvm_rd_o,
    output logic [NVM_ADDR_W-1:0] nvm_addr_o,
    input wire logic [7:0] nvm_data_i,
    // configuration register fields
    input wire usbd_cfg0_t usb_config_register_zero_i,
    // answer stream
    output logic tx_valid_o,
    output var usbd_tx_t tx_o,
    input wire logic tx_ready_i,
    output logic stall_o,
    output logic done_o
);
    usbd_state_t state_q;
    usbd_req_kind_t src_q;
    logic [7:0] cnt_q;
    logic [7:0] last_q;
    logic [3:0] burst_q;
    logic [NVM_ADDR_W-1:0] addr_q;
    usbd_tx_t tx_q;
    logic tx_valid_q;
    logic stall_q;
    logic done_q;

    logic ins_fire;
    logic req_fire;
    logic idx_ok;
    logic str_exists;
    logic [2:0] tbl_idx;
    usbd_str_entry_t ent;
    logic [7:0] xlen;
    logic [3:0] burst_sel;
    logic hs;
    logic send_last;

    // companion byte by position; nothing here comes from the image
    function automatic logic [7:0] comp_byte(input logic [7:0] idx, input logic [3:0] burst);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            COMP_IDX_LEN: b = COMP_LEN;
            COMP_IDX_TYPE: b = COMP_TYPE;
            COMP_IDX_BURST: b = {4'h0, burst};
            COMP_IDX_ATTR: b = COMP_ATTR;
            COMP_IDX_BPI_LO: b = COMP_BPI[7:0];
            COMP_IDX_BPI_HI: b = COMP_BPI[15:8];
            default: b = 8'h00;
        endcase
        return b;
    endfunction : comp_byte

    // insertion has priority so the companion lands right after its endpoint
    assign ins_fire = (state_q == ST_IDLE) && ep_desc_end_i && superspeed_i;
    assign req_ready_o = (state_q == ST_IDLE) && !ins_fire;
    assign req_fire = req_valid_i && req_ready_o;
    assign hs = tx_valid_q && tx_ready_i;
    assign send_last = (cnt_q == last_q);

    // string table lookup; langid is never looked at
    assign idx_ok = (req_i.index >= STR_IDX_FIRST) && (req_i.index <= STR_IDX_LAST);
    assign tbl_idx = idx_ok ? 3'(req_i.index - STR_IDX_FIRST) : 3'h0;
    assign ent = str_table_i[tbl_idx];
    assign str_exists = nvm_image_valid_i && idx_ok && !((ent.len == 8'h00) && (ent.offset == '0));

    // burst field chosen per direction; 4 bits keep it within 0..15
    assign burst_sel = (req_i.kind == REQ_COMP_IN) ? usb_config_register_zero_i.bulk_in_burst_size
                                                   : usb_config_register_zero_i.bulk_out_burst_size;

    // bytes to send, cut to what the host asked for
    always_comb begin
        xlen = COMP_LEN;
        if (req_i.kind == REQ_STRING) begin
            xlen = (req_i.max_len < {8'h00, ent.len}) ? req_i.max_len[7:0] : ent.len;
        end else if (req_i.max_len < {8'h00, COMP_LEN}) begin
            xlen = req_i.max_len[7:0];
        end
    end

    // sequencing of a transfer
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (ins_fire) begin
                        state_q <= ST_SEND;
                    end else if (req_fire && (xlen != 8'h00)) begin
                        if (req_i.kind != REQ_STRING) begin
                            state_q <= ST_SEND;
                        end else if (str_exists) begin
                            state_q <= ST_RD;
                        end
                    end
                end
                ST_RD: state_q <= ST_CAP;
                ST_CAP: state_q <= ST_SEND;
                ST_SEND: begin
                    if (hs) begin
                        if (send_last) begin
                            state_q <= ST_IDLE;
                        end else if (src_q == REQ_STRING) begin
                            state_q <= ST_RD;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // transfer bookkeeping: source, byte count, burst and image address
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            src_q <= REQ_STRING;
            cnt_q <= 8'h00;
            last_q <= 8'h00;
            burst_q <= BURST_DEFAULT;
            addr_q <= '0;
        end else if (ins_fire) begin
            src_q <= ep_is_in_i ? REQ_COMP_IN : REQ_COMP_OUT;
            cnt_q <= 8'h00;
            last_q <= COMP_IDX_BPI_HI;
            burst_q <= ep_is_in_i ? usb_config_register_zero_i.bulk_in_burst_size
                                  : usb_config_register_zero_i.bulk_out_burst_size;
        end else if (req_fire) begin
            src_q <= req_i.kind;
            cnt_q <= 8'h00;
            last_q <= 8'(xlen - 8'h01);
            burst_q <= burst_sel;
            addr_q <= ent.offset;
        end else if ((state_q == ST_SEND) && hs && !send_last) begin
            cnt_q <= 8'(cnt_q + 8'h01);
            addr_q <= NVM_ADDR_W'(addr_q + 1'b1);
        end
    end

    // answer byte register; string bytes pass through untouched
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_q <= '0;
            tx_valid_q <= 1'b0;
        end else if (ins_fire) begin
            tx_q <= '{data: COMP_LEN, last: 1'b0};
            tx_valid_q <= 1'b1;
        end else if (req_fire && (req_i.kind != REQ_STRING) && (xlen != 8'h00)) begin
            tx_q <= '{data: comp_byte(COMP_IDX_LEN, burst_sel), last: (xlen == 8'h01)};
            tx_valid_q <= 1'b1;
        end else if (state_q == ST_CAP) begin
            tx_q <= '{data: nvm_data_i, last: send_last};
            tx_valid_q <= 1'b1;
        end else if (hs) begin
            if (!send_last && (src_q != REQ_STRING)) begin
                tx_q <= '{data: comp_byte(8'(cnt_q + 8'h01), burst_q), last: (8'(cnt_q + 8'h01) == last_q)};
            end else begin
                tx_valid_q <= 1'b0;
            end
        end
    end

    // one-cycle status pulses: stall in the data stage, or transfer complete
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            stall_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            stall_q <= req_fire && (req_i.kind == REQ_STRING) && !str_exists;
            done_q <= (req_fire && (xlen == 8'h00) && ((req_i.kind != REQ_STRING) || str_exists))
                      || ((state_q == ST_SEND) && hs && send_last);
        end
    end

    // image read: one-cycle latency expected on nvm_data_i
    assign nvm_rd_o = (state_q == ST_RD);
    assign nvm_addr_o = addr_q;
    assign tx_o = tx_q;
    assign tx_valid_o = tx_valid_q;
    assign stall_o = stall_q;
    assign done_o = done_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_str_passthru;
        (state_q == ST_CAP) |=> (tx_o.data == $past(nvm_data_i)) && tx_valid_o;
    endproperty
    a_str_passthru: assert property (p_str_passthru) else $error("string byte altered");

    property p_stall_no_image;
        (req_fire && (req_i.kind == REQ_STRING) && !nvm_image_valid_i) |=> stall_o ##1 (state_q == ST_IDLE) && !tx_valid_o;
    endproperty
    a_stall_no_image: assert property (p_stall_no_image) else $error("missing stall without image");

    property p_in_header;
        (tx_valid_o && (src_q == REQ_COMP_IN) && (cnt_q == COMP_IDX_LEN)) |-> (tx_o.data == 8'h06);
    endproperty
    a_in_header: assert property (p_in_header) else $error("bulk-in companion length wrong");

    property p_out_type;
        (tx_valid_o && (src_q == REQ_COMP_OUT) && (cnt_q == COMP_IDX_TYPE)) |-> (tx_o.data == 8'h30);
    endproperty
    a_out_type: assert property (p_out_type) else $error("bulk-out companion type wrong");

    property p_in_burst;
        (req_fire && (req_i.kind == REQ_COMP_IN))
            |=> (burst_q == $past(usb_config_register_zero_i.bulk_in_burst_size));
    endproperty
    a_in_burst: assert property (p_in_burst) else $error("bulk-in burst not from field");

    property p_out_burst;
        (tx_valid_o && (src_q == REQ_COMP_OUT) && (cnt_q == COMP_IDX_BURST)) |-> (tx_o.data == {4'h0, burst_q});
    endproperty
    a_out_burst: assert property (p_out_burst) else $error("bulk-out burst byte wrong");

    // the byte above only mirrors burst_q, so the latch itself is held to the register field
    property p_out_latch;
        (req_fire && (req_i.kind == REQ_COMP_OUT))
            |=> (burst_q == $past(usb_config_register_zero_i.bulk_out_burst_size));
    endproperty
    a_out_latch: assert property (p_out_latch) else $error("bulk-out burst not from field");

    property p_burst_range;
        (tx_valid_o && (src_q != REQ_STRING) && (cnt_q == COMP_IDX_BURST)) |-> (tx_o.data[7:4] == 4'h0);
    endproperty
    a_burst_range: assert property (p_burst_range) else $error("burst beyond fifteen");

    property p_tail_zero;
        (tx_valid_o && (src_q != REQ_STRING) && (cnt_q >= COMP_IDX_ATTR)) |-> (tx_o.data == 8'h00);
    endproperty
    a_tail_zero: assert property (p_tail_zero) else $error("attributes or interval nonzero");

    property p_langid_ignored;
        (req_fire && (req_i.kind == REQ_STRING) && str_exists && (xlen != 8'h00)) |=> !stall_o ##2 tx_valid_o;
    endproperty
    a_langid_ignored: assert property (p_langid_ignored) else $error("existing string not served");

    property p_follow_ep;
        ins_fire |=> tx_valid_o && (tx_o.data == 8'h06)
            && (src_q == ($past(ep_is_in_i) ? REQ_COMP_IN : REQ_COMP_OUT));
    endproperty
    a_follow_ep: assert property (p_follow_ep) else $error("companion not placed after endpoint");

    c_string: cover property ((state_q == ST_SEND) && hs && send_last && (src_q == REQ_STRING));
    c_stall: cover property (stall_o);
    c_comp_in: cover property (hs && tx_o.last && (src_q == REQ_COMP_IN));
    c_insert: cover property (ins_fire ##[1:20] done_o);
endmodule : usbd_desc_resp
`default_nettype wire

// ==== testbench/usbd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host-side sink of descriptor bytes, able to throttle to half rate
module usbd_host_model import usbd_pkg::*; (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // throttle switch and answer stream from the device
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire usbd_tx_t tx_i,
    input wire logic stall_i,
    input wire logic done_i,
    output logic tx_ready_o
);
    logic [7:0] rx_q [64];
    int n_q;
    int last_q;
    int nlast_q;
    int stall_q;
    int done_q;
    logic tog_q;
    // toggling ready makes the device hold each byte across idle cycles
    always_ff @(posedge sys_clk_i) begin
        tog_q <= rst_i ? 1'b0 : ~tog_q;
    end
    assign tx_ready_o = slow_i ? tog_q : 1'b1;
    // bytes taken only on a real handshake edge
    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o && n_q < 64) begin
            rx_q[n_q] = tx_i.data;
            if (tx_i.last) begin
                last_q = n_q;
                nlast_q++;
            end
            n_q++;
        end
        stall_q += int'(stall_i);
        done_q += int'(done_i);
    end
    task automatic clear();
        n_q = 0;
        last_q = -1;
        nlast_q = 0;
        stall_q = 0;
        done_q = 0;
    endtask : clear
endmodule : usbd_host_model
`default_nettype wire

// ==== testbench/usbd_desc_resp_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module usbd_desc_resp_test import usbd_pkg::*;;
    typedef struct {usbd_req_kind_t k; logic [7:0] idx; logic [15:0] lang; logic [15:0] ml; logic img; int n;} usbd_row_t;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_ready_o, superspeed_i = 1'b0;
    logic ep_desc_end_i = 1'b0, ep_is_in_i = 1'b0, img = 1'b1, nvm_rd_o, slow = 1'b0, tx_ready_i;
    logic tx_valid_o, stall_o, done_o;
    logic [15:0] nvm_addr_o;
    logic [7:0] nvm_data_i = 8'h00;
    logic [7:0] mem [256];
    usbd_req_t req = '0;
    usbd_tx_t tx_o;
    usbd_str_entry_t tbl [NUM_STRINGS];
    usbd_cfg0_t cfg = usbd_cfg0_t'(8'h33); // register reset value: both bursts 03h
    int bad_count = 0, checked = 0;
    // index 3 is absent (length and offset zero), index 4 exists but is empty
    usbd_row_t rows [13] = '{
        '{REQ_STRING, 8'h01, 16'h0409, 16'h0040, 1'b1, 4}, '{REQ_STRING, 8'h02, 16'h0000, 16'h0040, 1'b1, 6},
        '{REQ_STRING, 8'h02, 16'hFFFF, 16'h0003, 1'b1, 3}, '{REQ_STRING, 8'h03, 16'h0409, 16'h0040, 1'b1, -1},
        '{REQ_STRING, 8'h04, 16'h0409, 16'h0040, 1'b1, 0}, '{REQ_STRING, 8'h05, 16'h0407, 16'h0040, 1'b1, 4},
        '{REQ_STRING, 8'h00, 16'h0409, 16'h0040, 1'b1, -1}, '{REQ_STRING, 8'h06, 16'h0409, 16'h0040, 1'b1, -1},
        '{REQ_STRING, 8'h01, 16'h0409, 16'h0040, 1'b0, -1}, '{REQ_COMP_IN, 8'h00, 16'h0000, 16'h0040, 1'b1, 6},
        '{REQ_COMP_OUT, 8'h00, 16'h0000, 16'h0040, 1'b1, 6}, '{REQ_COMP_IN, 8'h00, 16'h0000, 16'h0002, 1'b1, 2},
        '{REQ_COMP_OUT, 8'h00, 16'h0000, 16'h0000, 1'b1, 0}};

    usbd_desc_resp i_usbd_desc_resp (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_i(req), .req_ready_o(req_ready_o), .superspeed_i(superspeed_i), .ep_desc_end_i(ep_desc_end_i),
        .ep_is_in_i(ep_is_in_i), .nvm_image_valid_i(img), .str_table_i(tbl), .nvm_rd_o(nvm_rd_o),
        .nvm_addr_o(nvm_addr_o), .nvm_data_i(nvm_data_i), .usb_config_register_zero_i(cfg),
        .tx_valid_o(tx_valid_o), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .stall_o(stall_o), .done_o(done_o));
    usbd_host_model i_usbd_host_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow),
        .tx_valid_i(tx_valid_o), .tx_i(tx_o), .stall_i(stall_o), .done_i(done_o), .tx_ready_o(tx_ready_i));

    always #12.5 sys_clk_i = ~sys_clk_i;
    // image byte one cycle after the strobe; otherwise a changing pattern, never a stale byte
    always @(posedge sys_clk_i) begin
        nvm_data_i <= nvm_rd_o ? mem[nvm_addr_o[7:0]] : ~nvm_data_i;
    end

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // bounded idle wait; running out is a mismatch
    task automatic wait_ready();
        for (int k = 0; req_ready_o !== 1'b1; k++) begin
            if (k > 300) begin bad_count++; final_report(); end
            @(negedge sys_clk_i);
        end
    endtask : wait_ready
    function automatic logic [7:0] exp_comp(input usbd_req_kind_t k, input int i);
        logic [7:0] b [6];
        b = '{COMP_LEN, COMP_TYPE, {4'h0, k == REQ_COMP_IN ? cfg.bulk_in_burst_size : cfg.bulk_out_burst_size},
            COMP_ATTR, COMP_BPI[7:0], COMP_BPI[15:8]};
        return b[i];
    endfunction : exp_comp
    task automatic cmp(input usbd_req_kind_t k, input logic [7:0] idx, input int n);
        `CHK("count", n, i_usbd_host_model.n_q)
        for (int i = 0; i < n; i++) begin
            if (k == REQ_STRING) `CHK("str", mem[8'(tbl[idx - 1].offset + i)], i_usbd_host_model.rx_q[i])
            else `CHK("comp", exp_comp(k, i), i_usbd_host_model.rx_q[i])
        end
        if (n > 0) `CHK("last", n - 1, i_usbd_host_model.last_q)
        `CHK("last count", (n > 0) ? 1 : 0, i_usbd_host_model.nlast_q)
    endtask : cmp
    task automatic run(input usbd_row_t r);
        i_usbd_host_model.clear();
        img = r.img;
        req = '{r.k, r.idx, r.lang, r.ml};
        req_valid_i = 1'b1;
        wait_ready();
        @(negedge sys_clk_i);
        req_valid_i = 1'b0;
        for (int k = 0; i_usbd_host_model.stall_q + i_usbd_host_model.done_q == 0; k++) begin
            if (k > 300) begin bad_count++; final_report(); end
            @(negedge sys_clk_i);
        end
        `CHK("stall", r.n < 0, i_usbd_host_model.stall_q == 1)
        `CHK("done", r.n >= 0, i_usbd_host_model.done_q == 1)
        cmp(r.k, r.idx, r.n < 0 ? 0 : r.n);
        wait_ready();
    endtask : run

    initial begin
        for (int a = 0; a < 256; a++) mem[a] = 8'(a * 7 + 3);
        // well-formed headers; string 5 keeps a header that disagrees with its count
        mem[8'h10] = 8'h04;
        mem[8'h11] = STR_TYPE;
        mem[8'h20] = 8'h06;
        mem[8'h21] = STR_TYPE;
        tbl = '{'{8'h04, 16'h0010}, '{8'h06, 16'h0020}, '{8'h00, 16'h0000}, '{8'h00, 16'h0030}, '{8'h04, 16'h0040}};
        i_usbd_host_model.clear();
        repeat (5) @(negedge sys_clk_i);
        rst_i = 1'b0;
        foreach (rows[i]) run(rows[i]);
        // extreme burst fields, both in and out, under a throttling host
        slow = 1'b1;
        foreach (rows[i]) if (rows[i].n == 6) begin
            cfg = usbd_cfg0_t'(8'hF0);
            run(rows[i]);
            cfg = usbd_cfg0_t'(8'h0F);
            run(rows[i]);
        end
        run(rows[1]);
        // companion inserted after each endpoint descriptor at SuperSpeed only
        for (int e = 0; e < 4; e++) begin
            i_usbd_host_model.clear();
            superspeed_i = e[1];
            ep_is_in_i = e[0];
            ep_desc_end_i = 1'b1;
            @(negedge sys_clk_i);
            ep_desc_end_i = 1'b0;
            repeat (30) @(negedge sys_clk_i);
            cmp(e[0] ? REQ_COMP_IN : REQ_COMP_OUT, 8'h00, e[1] ? 6 : 0);
        end
        superspeed_i = 1'b0;
        // reset in mid-transfer returns to idle, then service resumes
        req = '{REQ_COMP_IN, 8'h00, 16'h0000, 16'h0040};
        req_valid_i = 1'b1;
        @(negedge sys_clk_i);
        req_valid_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        `CHK("rst valid", 1'b0, tx_valid_o)
        `CHK("rst ready", 1'b1, req_ready_o)
        rst_i = 1'b0;
        run(rows[10]);
        final_report();
    end
endmodule : usbd_desc_resp_test
`default_nettype wire
